// *** rtl/decoder_ctrl_regs.svh ***
`ifndef DECODER_CTRL_REGS_SVH
`define DECODER_CTRL_REGS_SVH
`define ADDR_RSVD_B        8'h2b
`define ADDR_RSVD_C        8'h2c
`define ADDR_RSVD_D        8'h2d
`define ADDR_RSVD_E        8'h2e
`define ADDR_STUFF_CTRL    8'h2f
`define ADDR_RSVD_30       8'h30
`define ADDR_GAIN_FORCE    8'h31
`define ADDR_RSVD_32       8'h32
`define ADDR_RSVD_33       8'h33
`define RST_RSVD_B         8'h63
`define RST_RSVD_C         8'h82
`define RST_RSVD_D         8'h0a
`define RST_RSVD_E         8'h00
`define RST_STUFF_CTRL     8'h00
`define RST_RSVD_30        8'h00
`define RST_GAIN_FORCE     8'h20
`define RST_RSVD_32        8'h00
`define RST_RSVD_33        8'h00
`define STUFF_EN_BIT       4
`define STUFF_SEL_HI       3
`define STUFF_SEL_LO       2
`define GAIN_DIS_BIT       6
`define GAIN_VAL_HI        5
`define STUFF_STEP_BYTES   11'h020
`define STUFF_BLANK_BYTE   8'h80
`endif

// *** rtl/decoder_ctrl_pkg.sv ***
package decoder_ctrl_pkg;
   typedef enum logic [1:0] {ST_PASS, ST_STUFF} stuff_state_t;
endpackage

// *** rtl/stuff_if.sv ***
`timescale 1ns/1ps
interface stuff_if;
   logic        enable;
   logic [1:0]  sel;
   modport ctrl (output enable, output sel);
   modport engine (input enable, input sel);
endinterface

// *** rtl/stuff_inserter.sv ***
`timescale 1ns/1ps
`include "decoder_ctrl_regs.svh"
module stuff_inserter
   import decoder_ctrl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   stuff_if.engine         cfg,
   input  wire logic [7:0] in_data,
   input  wire logic       in_valid,
   input  wire logic       in_eav_end,
   output logic            in_ready,
   output logic [7:0]      out_data,
   output logic            out_valid
);
   stuff_state_t st_q, st_d;
   logic [6:0]   cnt_q, cnt_d;
   logic [7:0]   data_q, data_d;
   logic         vld_q, vld_d;
   logic [6:0]   total;

   // Size is taken at the EAV so a mid-gap write cannot tear a line
   always_comb
   begin
      total    = 7'({cfg.sel, 5'h00});
      st_d     = st_q;
      cnt_d    = cnt_q;
      data_d   = data_q;
      vld_d    = 1'b0;
      in_ready = (st_q == ST_PASS);
      case (st_q)
         ST_PASS:
         begin
            if (in_valid)
            begin
               data_d = in_data;
               vld_d  = 1'b1;
               if (in_eav_end && cfg.enable && cfg.sel != 2'b00)
               begin
                  st_d  = ST_STUFF;
                  cnt_d = total;
               end
            end
         end
         ST_STUFF:
         begin
            data_d = `STUFF_BLANK_BYTE;
            vld_d  = 1'b1;
            cnt_d  = cnt_q - 7'd1;
            if (cnt_q == 7'd1)
               st_d = ST_PASS;
         end
         default:
            st_d = ST_PASS;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         st_q   <= ST_PASS;
         cnt_q  <= 7'h00;
         data_q <= 8'h00;
         vld_q  <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         data_q <= data_d;
         vld_q  <= vld_d;
      end
   end

   assign out_data  = data_q;
   assign out_valid = vld_q;
endmodule

// *** rtl/decoder_ctrl_regs_2b_33.sv ***
// How it works
// - Stuffing enable set with a nonzero size field inserts blanking bytes between EAV and SAV; clear inserts none.
// - Inserted byte count per preamble is the size field times 32.
// - Size field has no effect while stuffing enable is clear.
// - Gain-loop disable drives gain command from forced field instead of regulator.
// - Six-bit forced gain is held and used only in forced mode.
// - Reset loads gain control 0x20 and stuffing control zero.
`timescale 1ns/1ps
`include "decoder_ctrl_regs.svh"
module decoder_ctrl_regs_2b_33
   import decoder_ctrl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   output logic            reg_hit,
   input  wire logic [5:0] auto_gain,
   output logic [5:0]      gain_cmd,
   output logic            gain_loop_disable,
   input  wire logic [7:0] in_data,
   input  wire logic       in_valid,
   input  wire logic       in_eav_end,
   output logic            in_ready,
   output logic [7:0]      out_data,
   output logic            out_valid
);
   logic [7:0] rsvd_b_q, rsvd_c_q, rsvd_d_q, rsvd_e_q, rsvd_30_q, rsvd_32_q, rsvd_33_q;
   logic [7:0] rsvd_b_d, rsvd_c_d, rsvd_d_d, rsvd_e_d, rsvd_30_d, rsvd_32_d, rsvd_33_d;
   logic [7:0] stuff_q, stuff_d;
   logic [7:0] gainf_q, gainf_d;
   logic [7:0] rdata_q, rdata_d;
   logic [5:0] gcmd_q, gcmd_d;
   stuff_if    stuff_cfg ();

   // Reserved registers are stored as written; the host keeps the fixed patterns
   always_comb
   begin
      rsvd_b_d  = rsvd_b_q;
      rsvd_c_d  = rsvd_c_q;
      rsvd_d_d  = rsvd_d_q;
      rsvd_e_d  = rsvd_e_q;
      rsvd_30_d = rsvd_30_q;
      rsvd_32_d = rsvd_32_q;
      rsvd_33_d = rsvd_33_q;
      stuff_d   = stuff_q;
      gainf_d   = gainf_q;
      if (reg_wr)
      begin
         case (reg_addr)
            `ADDR_RSVD_B:     rsvd_b_d  = reg_wdata;
            `ADDR_RSVD_C:     rsvd_c_d  = reg_wdata;
            `ADDR_RSVD_D:     rsvd_d_d  = reg_wdata;
            `ADDR_RSVD_E:     rsvd_e_d  = reg_wdata;
            `ADDR_STUFF_CTRL: stuff_d   = reg_wdata;
            `ADDR_RSVD_30:    rsvd_30_d = reg_wdata;
            `ADDR_GAIN_FORCE: gainf_d   = reg_wdata;
            `ADDR_RSVD_32:    rsvd_32_d = reg_wdata;
            `ADDR_RSVD_33:    rsvd_33_d = reg_wdata;
            default:          stuff_d   = stuff_q;
         endcase
      end
   end

   // Read data is registered one cycle after the strobe; unmapped reads give zero
   always_comb
   begin
      rdata_d = rdata_q;
      if (reg_rd)
      begin
         case (reg_addr)
            `ADDR_RSVD_B:     rdata_d = rsvd_b_q;
            `ADDR_RSVD_C:     rdata_d = rsvd_c_q;
            `ADDR_RSVD_D:     rdata_d = rsvd_d_q;
            `ADDR_RSVD_E:     rdata_d = rsvd_e_q;
            `ADDR_STUFF_CTRL: rdata_d = stuff_q;
            `ADDR_RSVD_30:    rdata_d = rsvd_30_q;
            `ADDR_GAIN_FORCE: rdata_d = gainf_q;
            `ADDR_RSVD_32:    rdata_d = rsvd_32_q;
            `ADDR_RSVD_33:    rdata_d = rsvd_33_q;
            default:          rdata_d = 8'h00;
         endcase
      end
   end

   // Gain command is registered so a mode switch never glitches the converter
   always_comb
   begin
      if (gainf_q[`GAIN_DIS_BIT])
         gcmd_d = gainf_q[`GAIN_VAL_HI:0];
      else
         gcmd_d = auto_gain;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         rsvd_b_q  <= `RST_RSVD_B;
         rsvd_c_q  <= `RST_RSVD_C;
         rsvd_d_q  <= `RST_RSVD_D;
         rsvd_e_q  <= `RST_RSVD_E;
         stuff_q   <= `RST_STUFF_CTRL;
         rsvd_30_q <= `RST_RSVD_30;
         gainf_q   <= `RST_GAIN_FORCE;
         rsvd_32_q <= `RST_RSVD_32;
         rsvd_33_q <= `RST_RSVD_33;
         rdata_q   <= 8'h00;
         gcmd_q    <= 6'h00;
      end
      else
      begin
         rsvd_b_q  <= rsvd_b_d;
         rsvd_c_q  <= rsvd_c_d;
         rsvd_d_q  <= rsvd_d_d;
         rsvd_e_q  <= rsvd_e_d;
         stuff_q   <= stuff_d;
         rsvd_30_q <= rsvd_30_d;
         gainf_q   <= gainf_d;
         rsvd_32_q <= rsvd_32_d;
         rsvd_33_q <= rsvd_33_d;
         rdata_q   <= rdata_d;
         gcmd_q    <= gcmd_d;
      end
   end

   assign reg_hit           = (reg_addr >= `ADDR_RSVD_B) && (reg_addr <= `ADDR_RSVD_33);
   assign reg_rdata         = rdata_q;
   assign gain_cmd          = gcmd_q;
   assign gain_loop_disable = gainf_q[`GAIN_DIS_BIT];

   assign stuff_cfg.enable = stuff_q[`STUFF_EN_BIT];
   assign stuff_cfg.sel    = stuff_q[`STUFF_SEL_HI:`STUFF_SEL_LO];

   stuff_inserter u_stuff
   (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .cfg        (stuff_cfg.engine),
      .in_data    (in_data),
      .in_valid   (in_valid),
      .in_eav_end (in_eav_end),
      .in_ready   (in_ready),
      .out_data   (out_data),
      .out_valid  (out_valid)
   );
endmodule

// *** sim/decoder_ctrl_regs_2b_33_asserts.sv ***
`timescale 1ns/1ps
`include "decoder_ctrl_regs.svh"
module decoder_ctrl_regs_2b_33_asserts (
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [5:0] auto_gain,
   input wire logic [5:0] gain_cmd,
   input wire logic       gain_loop_disable,
   input wire logic [7:0] in_data,
   input wire logic       in_valid,
   input wire logic       in_eav_end,
   input wire logic       in_ready,
   input wire logic [7:0] out_data,
   input wire logic       out_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [7:0] st_q;
   logic [1:0] sz_q;
   logic [6:0] cnt_q;
   wire        eav = in_valid && in_ready && in_eav_end;
   // Mirror of the stuffing register; size latched at EAV, as the engine does
   always_ff @(posedge ref_clk)
   begin
      st_q  <= !rstn ? 8'h00 : (reg_wr && reg_addr == `ADDR_STUFF_CTRL) ? reg_wdata : st_q;
      sz_q  <= !rstn ? 2'b00 : eav ? (st_q[4] ? st_q[3:2] : 2'b00) : sz_q;
      cnt_q <= (!rstn || in_ready) ? 7'h00 : cnt_q + 7'h01;
   end
   property p_pass; in_valid && in_ready |=> out_valid && out_data == $past(in_data); endproperty
   a_pass: assert property (p_pass) else $error("byte not passed through");
   property p_fill; !in_ready |=> out_valid && out_data == `STUFF_BLANK_BYTE; endproperty
   a_fill: assert property (p_fill) else $error("fill byte missing");
   property p_len; $rose(in_ready) |-> cnt_q == {sz_q, 5'h00}; endproperty
   a_len: assert property (p_len) else $error("wrong fill count");
   property p_off; eav && !st_q[4] |=> in_ready [*2]; endproperty
   a_off: assert property (p_off) else $error("stuffing while disabled");
   property p_auto; $past(rstn) && !gain_loop_disable && $past(!gain_loop_disable)
      |-> gain_cmd == $past(auto_gain); endproperty
   a_auto: assert property (p_auto) else $error("gain not from regulator");
   property p_dis; reg_wr && reg_addr == `ADDR_GAIN_FORCE
      |=> gain_loop_disable == $past(reg_wdata[6]); endproperty
   a_dis: assert property (p_dis) else $error("disable bit not stored");
   property p_force; reg_wr && reg_addr == `ADDR_GAIN_FORCE && reg_wdata[6]
      |=> ##1 gain_cmd == $past(reg_wdata[5:0], 2); endproperty
   a_force: assert property (p_force) else $error("forced gain not applied");
   property p_rst; $rose(rstn) |-> !gain_loop_disable && in_ready; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule

// *** sim/video_sink.sv ***
`timescale 1ns/1ps
module video_sink (
   input wire logic       ref_clk,
   input wire logic [7:0] out_data,
   input wire logic       out_valid,
   output int             n_fill
);
   // Counts blanking fill bytes; line data in the bench never uses that value
   // One process owns the counter, so it has a single driver
   initial
   begin
      n_fill = 0;
      forever @(posedge ref_clk) if (out_valid === 1'b1 && out_data === 8'h80) n_fill++;
   end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   logic       ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, in_valid = 0, in_eav_end = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, in_data = 8'h00, reg_rdata, out_data;
   logic [5:0] auto_gain = 6'h15, gain_cmd;
   logic       reg_hit, gain_loop_disable, in_ready, out_valid;
   int         n_errors = 0, cmp_count = 0, n_fill, f0, k;
   localparam logic [7:0] RV[9] = '{8'h63, 8'h82, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
   localparam logic [7:0] SC[4] = '{8'h10, 8'h14, 8'h18, 8'h1c};
   decoder_ctrl_regs_2b_33 decoder_ctrl_regs_2b_33_inst (.ref_clk, .rstn, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .auto_gain, .gain_cmd, .gain_loop_disable,
      .in_data, .in_valid, .in_eav_end, .in_ready, .out_data, .out_valid);
   video_sink video_sink_inst (.ref_clk, .out_data, .out_valid, .n_fill);
   initial forever #5 ref_clk = ~ref_clk;
   task give_verdict;
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      `CHK(reg_rdata, e)
   endtask
   task send(input logic [7:0] d, input logic e);
      int i;
      @(posedge ref_clk);
      in_valid <= 1'b1; in_data <= d; in_eav_end <= e;
      i = 0;
      do @(negedge ref_clk); while (in_ready !== 1'b1 && ++i < 200);
      if (i >= 200) begin n_errors++; give_verdict; end
      @(posedge ref_clk);
      in_valid <= 1'b0; in_eav_end <= 1'b0;
   endtask
   task line(input int exp);
      f0 = n_fill;
      send(8'hb6, 1'b1);
      send(8'h11, 1'b0);
      @(negedge ref_clk);
      `CHK(n_fill - f0, exp)
   endtask
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      for (k = 0; k < 9; k++) rd(8'h2b + k[7:0], RV[k]);
      `CHK(reg_hit, 1'b1)
      rd(8'h34, 8'h00);
      `CHK(reg_hit, 1'b0)
      rd(8'h2a, 8'h00);
      `CHK(reg_hit, 1'b0)
      wr(8'h2b, 8'h63);
      wr(8'h2c, 8'h82);
      wr(8'h2d, 8'h0a);
      line(0);
      wr(8'h2f, 8'h0c);
      line(0);
      for (k = 0; k < 4; k++) begin wr(8'h2f, SC[k]); line(32 * k); end
      `CHK(gain_cmd, 6'h15)
      wr(8'h31, 8'h6a);
      auto_gain <= 6'h07;
      repeat (2) @(negedge ref_clk);
      `CHK(gain_cmd, 6'h2a)
      `CHK(gain_loop_disable, 1'b1)
      rd(8'h31, 8'h6a);
      wr(8'h31, 8'h20);
      repeat (2) @(negedge ref_clk);
      `CHK(gain_cmd, 6'h07)
      // Mid-run reset must bring both control registers back to their defaults
      wr(8'h2f, 8'h14);
      wr(8'h31, 8'h6a);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(8'h2f, 8'h00);
      rd(8'h31, 8'h20);
      `CHK(gain_loop_disable, 1'b0)
      line(0);
      give_verdict;
   end
endmodule
bind decoder_ctrl_regs_2b_33 decoder_ctrl_regs_2b_33_asserts decoder_ctrl_regs_2b_33_asserts_inst (
   .ref_clk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .auto_gain, .gain_cmd, .gain_loop_disable,
   .in_data, .in_valid, .in_eav_end, .in_ready, .out_data, .out_valid);
